/* common/clock_gen_pkg.sv */
package clock_gen_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] BWC_OFS = 8'h04;
  localparam logic [7:0] PROG_OFS = 8'h08;
  localparam logic [7:0] CENTER_OFS = 8'h0c;

  // Loop control register fields
  localparam int CTRL_IE_BIT = 7;
  localparam int CTRL_FLAG_BIT = 6;
  localparam int CTRL_ON_BIT = 5;
  localparam int CTRL_BCS_BIT = 4;

  // Bandwidth control register fields
  localparam int BWC_AUTO_BIT = 7;
  localparam int BWC_LOCK_BIT = 6;
  localparam int BWC_ACQ_BIT = 5;

  // Programming register fields: multiplier high nibble, range low nibble
  localparam int PROG_MULT_LSB = 4;
  localparam int PROG_RANGE_LSB = 0;
  localparam logic [7:0] PROG_RST = 8'h11;

  // Nominal VCO centre frequency in Hz
  localparam logic [31:0] NOM_CENTER_HZ = 32'd4915200;

  // Period mismatch windows, in pclk cycles
  localparam int TRK_TOL = 2;
  localparam int UNT_TOL = 4;
  localparam int LOCK_TOL = 1;
  localparam int UNL_TOL = 3;

  // Source edges to wait for while the base clock is held
  localparam logic [1:0] SWAP_EDGES = 2'd3;

  typedef enum logic [1:0] {
    SEL_RUN = 2'b01,
    SEL_HOLD = 2'b10
  } sel_state_t;

  typedef struct packed {
    logic up;
    logic down;
  } pump_t;

  typedef struct packed {
    logic [3:0] mult;
    logic [3:0] range;
  } prog_t;

endpackage

/* sim/clock_source_model.sv */
`timescale 1ns/10ps
`default_nettype none
module clock_source_model #(
  parameter int XTAL_HALF = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Controls
  input wire logic osc_run,
  input wire logic [7:0] vco_half,
  // Generated clocks
  output logic crystal_clock,
  output logic vco_clock
);
  logic [7:0] xcnt_q;
  logic [7:0] vcnt_q;

  // crystal follows enable
  // A stopped oscillator parks low, as a dead crystal would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xcnt_q <= 8'h00;
      crystal_clock <= 1'b0;
    end else if (!osc_run) begin
      xcnt_q <= 8'h00;
      crystal_clock <= 1'b0;
    end else if (xcnt_q >= 8'(XTAL_HALF - 1)) begin
      xcnt_q <= 8'h00;
      crystal_clock <= !crystal_clock;
    end else begin
      xcnt_q <= xcnt_q + 8'h01;
    end
  end

  // Compare with >= so a shorter half period takes effect at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vcnt_q <= 8'h00;
      vco_clock <= 1'b0;
    end else if (vco_half == 8'h00) begin
      vcnt_q <= 8'h00;
      vco_clock <= 1'b0;
    end else if (vcnt_q >= vco_half - 8'h01) begin
      vcnt_q <= 8'h00;
      vco_clock <= !vco_clock;
    end else begin
      vcnt_q <= vcnt_q + 8'h01;
    end
  end
endmodule // clock_source_model
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import clock_gen_pkg::*;

  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic osc_req;
  logic crystal_clock;
  logic vco_clock;
  logic osc_run;
  logic filter_tracking;
  logic base_clock_out;
  logic irq;
  logic lref;
  logic fref;
  logic fbclk;
  pump_t pump;
  logic [7:0] vco_half;
  logic [31:0] rdat;
  logic rerr;
  int fails;
  int check_count;
  int cyc;
  int n;

  clock_gen_control clock_gen_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .oscillator_enable_request(osc_req),
    .crystal_clock(crystal_clock), .vco_clock(vco_clock), .oscillator_run(osc_run),
    .loop_reference_clock(lref), .final_reference_clock(fref), .vco_feedback_clock(fbclk),
    .correction_pulse(pump), .filter_tracking(filter_tracking),
    .base_clock_out(base_clock_out), .clock_unit_interrupt(irq)
  );

  clock_source_model clock_source_model_inst (
    .pclk(pclk), .presetn(presetn), .osc_run(osc_run), .vco_half(vco_half),
    .crystal_clock(crystal_clock), .vco_clock(vco_clock)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask

  // Poll the lock status; the timeout guards a loop that never settles
  task automatic wait_lock(input logic v);
    for (int i = 0; i < 200; i++) begin
      apb(1'b0, BWC_OFS, 32'h0);
      if (rdat[BWC_LOCK_BIT] === v) break;
    end
  endtask

  // Cycles between two rising edges of the base clock
  task automatic base_period();
    int k;
    logic p;
    k = 0;
    n = 0;
    p = base_clock_out;
    while (k < 2 && n < 400) begin
      @(posedge pclk);
      n++;
      if (base_clock_out === 1'b1 && p === 1'b0) begin
        k++;
        if (k == 1) n = 0;
      end
      p = base_clock_out;
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #20 pclk = !pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    osc_req = 1'b1;
    vco_half = 8'h04;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTRL_OFS, 32'h0);
    rd(BWC_OFS, 32'h0);
    rd(PROG_OFS, 32'h11);
    rd(CENTER_OFS, NOM_CENTER_HZ);
    rd(8'h10, 32'h0);
    check({31'h0, rerr}, 32'h1);
    wr(BWC_OFS, 32'h20); // loop still off, no wait owed
    rd(BWC_OFS, 32'h20);
    check({31'h0, filter_tracking}, 32'h1);
    wr(BWC_OFS, 32'h00);
    // Let the write land before looking at the mode output
    @(posedge pclk);
    check({31'h0, filter_tracking}, 32'h0);
    wr(CTRL_OFS, 32'h80);
    rd(CTRL_OFS, 32'h0);
    base_period();
    check(n, 32'd16);
    wr(CTRL_OFS, 32'h10);
    rd(CTRL_OFS, 32'h0);
    wr(CTRL_OFS, 32'h30);
    rd(CTRL_OFS, 32'h0);
    // Manual mode kept acquisition clear before power-on
    wr(BWC_OFS, 32'h80);
    wr(CTRL_OFS, 32'ha0);
    wait_lock(1'b1);
    rd(BWC_OFS, 32'he0);
    rd(CTRL_OFS, 32'he0);
    check({31'h0, irq}, 32'h1);
    wr(BWC_OFS, 32'h80);
    rd(BWC_OFS, 32'he0);
    wr(CTRL_OFS, 32'he0);
    rd(CTRL_OFS, 32'ha0);
    check({31'h0, irq}, 32'h0);
    vco_half <= 8'h08;
    wait_lock(1'b0);
    // Tracking may drop a feedback period after lock does
    repeat (40) @(posedge pclk);
    rd(BWC_OFS, 32'h80);
    rd(CTRL_OFS, 32'he0);
    check({31'h0, irq}, 32'h1);
    wr(CTRL_OFS, 32'he0);
    wr(PROG_OFS, 32'h21);
    vco_half <= 8'h02;
    wait_lock(1'b1);
    rd(BWC_OFS, 32'he0);
    // VCO chosen only once settled
    wr(CTRL_OFS, 32'hb0);
    rd(CTRL_OFS, 32'hf0);
    base_period();
    check(n, 32'd8);
    check({31'h0, filter_tracking}, 32'h1);
    wr(CTRL_OFS, 32'h90);
    rd(CTRL_OFS, 32'hf0);
    wr(PROG_OFS, 32'h20);
    rd(CTRL_OFS, 32'he0);
    check({31'h0, rdat[CTRL_BCS_BIT]}, 32'h0);
    rd(CENTER_OFS, 32'h0);
    check({30'h0, pump}, 32'h0);
    base_period();
    check(n, 32'd16);
    osc_req <= 1'b0;
    repeat (4) @(posedge pclk);
    check({30'h0, osc_run, crystal_clock}, 32'h0);
    check({29'h0, lref, fref, fbclk}, 32'h0);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire

/* src/clock_gen_control.sv */
// Behaviour
// - Base clock is selected source divided by two
// - Oscillator runs only while enable request held
// - Crystal buffered to reference, then final reference
// - Modulo divider gives feedback clock from VCO
// - Phase detector pulses show phase error direction
// - Lock detector compares feedback and reference frequency
// - Acquisition reads zero; otherwise loop is tracking
// - Automatic mode switches filter mode by itself
// - Automatic mode: acquisition bit read-only status
// - Tracking entered within, left outside tolerance
// - Automatic mode: settled flag read-only lock state
// - Settled set within lock, cleared beyond unlock
// - Enabled interrupt on every settled flag toggle
// - Manual mode: acquisition bit writable filter control
// - Manual mode: no settled flag, no interrupt
// - Centre frequency is range factor times nominal
// - Loop tracks once VCO frequency nearly correct
// - Multiplier zero acts as one; range zero disables
// - Base clock held across source switch
// - Manual mode forces enable, flags to zero
// - Programming register holds multiplier and range
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module clock_gen_control #(
  parameter int CNT_W = 12
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator and VCO
  input wire logic oscillator_enable_request,
  input wire logic crystal_clock,
  input wire logic vco_clock,
  output logic oscillator_run,
  // Loop signals
  output logic loop_reference_clock,
  output logic final_reference_clock,
  output logic vco_feedback_clock,
  output clock_gen_pkg::pump_t correction_pulse,
  output logic filter_tracking,
  // System side
  output logic base_clock_out,
  output logic clock_unit_interrupt
);
  import clock_gen_pkg::*;

  // Counter must hold a reference period, yet stay cheap
  if (CNT_W < 4 || CNT_W > 24) begin : g_cnt_w_check
    $error("CNT_W out of range");
  end

  logic ie_q, flag_q, on_q, bcs_q, auto_q, acq_sw_q;
  prog_t prog_q;
  logic osc_q, xtal_prev_q, vco_prev_q;
  logic xtal_rise, vco_rise, loop_active;
  logic ref_rise, fb_rise;
  logic wr, rd_ok, wr_ctrl, wr_bwc, wr_prog;
  logic [CNT_W-1:0] ref_cnt_q, fb_cnt_q, ref_per_q, diff;
  logic track_q, lock_q, lock_prev_q;
  logic flag_set;
  sel_state_t sel_q;
  logic cur_src_q;
  logic [1:0] xcnt_q, vcnt_q;
  logic [31:0] center_q;

  // Input edges, oscillator gated by the integration logic request
  // oscillator gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_q <= 1'b0;
      xtal_prev_q <= 1'b0;
      vco_prev_q <= 1'b0;
    end else begin
      osc_q <= oscillator_enable_request;
      xtal_prev_q <= crystal_clock && osc_q;
      vco_prev_q <= vco_clock;
    end
  end
  assign oscillator_run = osc_q;
  assign xtal_rise = crystal_clock && osc_q && !xtal_prev_q;
  assign vco_rise = vco_clock && !vco_prev_q && loop_active;
  assign loop_active = on_q && (prog_q.range != 4'h0) && osc_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_reference_clock <= 1'b0;
      final_reference_clock <= 1'b0;
    end else begin
      loop_reference_clock <= crystal_clock && osc_q;
      final_reference_clock <= loop_reference_clock;
    end
  end
  assign ref_rise = xtal_rise && loop_active;

  vco_modulo_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .enable(loop_active),
    .divisor(prog_q.mult),
    .vco_level(vco_clock),
    .vco_rise(vco_rise),
    .fb_clk_q(vco_feedback_clock),
    .fb_rise(fb_rise)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      correction_pulse <= '0;
    end else if (!loop_active || (ref_rise && fb_rise)) begin
      correction_pulse <= '0;
    end else if (ref_rise) begin
      correction_pulse.up <= !correction_pulse.down;
      correction_pulse.down <= 1'b0;
    end else if (fb_rise) begin
      correction_pulse.down <= !correction_pulse.up;
      correction_pulse.up <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_q <= '0;
      fb_cnt_q <= '0;
      ref_per_q <= '0;
    end else if (!loop_active) begin
      ref_cnt_q <= '0;
      fb_cnt_q <= '0;
      ref_per_q <= '0;
    end else begin
      if (ref_rise) begin
        ref_per_q <= ref_cnt_q;
        ref_cnt_q <= '0;
      end else if (ref_cnt_q != '1) begin
        ref_cnt_q <= ref_cnt_q + 1'b1;
      end
      if (fb_rise) begin
        fb_cnt_q <= '0;
      end else if (fb_cnt_q != '1) begin
        fb_cnt_q <= fb_cnt_q + 1'b1;
      end
    end
  end
  assign diff = (fb_cnt_q > ref_per_q) ? fb_cnt_q - ref_per_q : ref_per_q - fb_cnt_q;

  // frequency comparison at each feedback edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      track_q <= 1'b0;
    end else if (!loop_active) begin
      track_q <= 1'b0;
    end else if (fb_rise && ref_per_q != '0) begin
      if (diff <= CNT_W'(TRK_TOL)) begin
        track_q <= 1'b1;
      end else if (diff > CNT_W'(UNT_TOL)) begin
        track_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= 1'b0;
    end else if (!loop_active) begin
      lock_q <= 1'b0;
    end else if (fb_rise && ref_per_q != '0) begin
      if (diff <= CNT_W'(LOCK_TOL)) begin
        lock_q <= 1'b1;
      end else if (diff > CNT_W'(UNL_TOL)) begin
        lock_q <= 1'b0;
      end
    end
  end

  // APB decode; zero-wait slave
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign wr_ctrl = wr && paddr == CTRL_OFS;
  assign wr_bwc = wr && paddr == BWC_OFS;
  assign wr_prog = wr && paddr == PROG_OFS;
  always_comb begin
    if (paddr == CTRL_OFS) begin
      rd_ok = 1'b1;
    end else if (paddr == BWC_OFS) begin
      rd_ok = 1'b1;
    end else if (paddr == PROG_OFS) begin
      rd_ok = 1'b1;
    end else if (paddr == CENTER_OFS) begin
      rd_ok = 1'b1;
    end else begin
      rd_ok = 1'b0;
    end
  end
  assign pslverr = psel && penable && !rd_ok;

  always_comb begin
    prdata = 32'h0;
    if (paddr == CTRL_OFS) begin
      prdata[CTRL_IE_BIT] = ie_q;
      prdata[CTRL_FLAG_BIT] = flag_q;
      prdata[CTRL_ON_BIT] = on_q;
      prdata[CTRL_BCS_BIT] = bcs_q;
    end else if (paddr == BWC_OFS) begin
      prdata[BWC_AUTO_BIT] = auto_q;
      prdata[BWC_LOCK_BIT] = auto_q && lock_q;
      prdata[BWC_ACQ_BIT] = filter_tracking;
    end else if (paddr == PROG_OFS) begin
      prdata[7:0] = prog_q;
    end else if (paddr == CENTER_OFS) begin
      prdata = center_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_q <= PROG_RST;
    end else if (wr_prog) begin
      prog_q.mult <= pwdata[PROG_MULT_LSB +: 4];
      prog_q.range <= pwdata[PROG_RANGE_LSB +: 4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      center_q <= 32'h0;
    end else begin
      center_q <= 32'(prog_q.range) * NOM_CENTER_HZ;
    end
  end

  // Power and source select interlocks; a write that flips both is ignored
  // VCO refused while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q <= 1'b0;
      bcs_q <= 1'b0;
    end else if (wr_ctrl && !((pwdata[CTRL_ON_BIT] != on_q) &&
                             (pwdata[CTRL_BCS_BIT] != bcs_q))) begin
      on_q <= pwdata[CTRL_ON_BIT] || bcs_q;
      bcs_q <= pwdata[CTRL_BCS_BIT] && on_q && (prog_q.range != 4'h0);
    end else if (!on_q || prog_q.range == 4'h0) begin
      bcs_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_q <= 1'b0;
      acq_sw_q <= 1'b0;
    end else if (wr_bwc) begin
      auto_q <= pwdata[BWC_AUTO_BIT];
      if (!auto_q) begin
        acq_sw_q <= pwdata[BWC_ACQ_BIT];
      end
    end
  end
  assign filter_tracking = auto_q ? track_q : acq_sw_q;

  // enable forced to zero in manual mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_q <= 1'b0;
    end else if (!auto_q) begin
      ie_q <= 1'b0;
    end else if (wr_ctrl) begin
      ie_q <= pwdata[CTRL_IE_BIT];
    end
  end

  // flag on every lock toggle; set beats a write-one clear
  // no flag in manual mode
  // Last cycle's lock state, so a toggle in either direction is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_prev_q <= 1'b0;
    end else begin
      lock_prev_q <= lock_q;
    end
  end
  assign flag_set = auto_q && (lock_q != lock_prev_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (!auto_q) begin
      flag_q <= 1'b0;
    end else if (flag_set) begin
      flag_q <= 1'b1;
    end else if (wr_ctrl && pwdata[CTRL_FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_unit_interrupt <= 1'b0;
    end else begin
      clock_unit_interrupt <= flag_q && ie_q && auto_q;
    end
  end

  // hold while three edges of each source pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= SEL_RUN;
      cur_src_q <= 1'b0;
      xcnt_q <= 2'd0;
      vcnt_q <= 2'd0;
    end else begin
      case (sel_q)
        SEL_RUN: begin
          xcnt_q <= 2'd0;
          vcnt_q <= 2'd0;
          if (bcs_q != cur_src_q) begin
            sel_q <= SEL_HOLD;
          end
        end
        SEL_HOLD: begin
          if (xtal_rise && xcnt_q != SWAP_EDGES) begin
            xcnt_q <= xcnt_q + 2'd1;
          end
          if (vco_rise && vcnt_q != SWAP_EDGES) begin
            vcnt_q <= vcnt_q + 2'd1;
          end
          // A stopped VCO cannot stall the return to crystal
          if ((xcnt_q == SWAP_EDGES || !osc_q) &&
              (vcnt_q == SWAP_EDGES || !loop_active)) begin
            cur_src_q <= bcs_q;
            sel_q <= SEL_RUN;
          end
        end
        default: begin
          sel_q <= SEL_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_clock_out <= 1'b0;
    end else if (sel_q == SEL_RUN) begin
      if (cur_src_q ? vco_rise : xtal_rise) begin
        base_clock_out <= !base_clock_out;
      end
    end
  end

  sequence s_held_two;
    (sel_q == SEL_HOLD) [*2];
  endsequence

  sequence s_lock_moves;
    auto_q && $changed(lock_q);
  endsequence

  AST_BASE_STATIC: assert property (@(posedge pclk) disable iff (!presetn)
    s_held_two |-> $stable(base_clock_out))
    else $error("base clock moved during hold");

  AST_VCO_REFUSED: assert property (@(posedge pclk) disable iff (!presetn)
    (!on_q || prog_q.range == 4'h0) |=> !bcs_q)
    else $error("source select kept with loop disabled");

  AST_MANUAL_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_q) [*2] |-> !clock_unit_interrupt && !flag_q)
    else $error("manual mode raised a flag or interrupt");

  AST_FLAG_SETS: assert property (@(posedge pclk) disable iff (!presetn)
    s_lock_moves ##1 auto_q |-> flag_q ##1 (clock_unit_interrupt == ie_q))
    else $error("lock toggle did not raise the flag");

  AST_REF_CHAIN: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 final_reference_clock == $past(loop_reference_clock))
    else $error("final reference not one stage behind");

  AST_PUMP_EXCL: assert property (@(posedge pclk) disable iff (!presetn)
    !(correction_pulse.up && correction_pulse.down))
    else $error("both correction directions active");

  AST_IE_FORCED: assert property (@(posedge pclk) disable iff (!presetn)
    !auto_q |=> !ie_q)
    else $error("interrupt enable set in manual mode");

  AST_ACQ_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_bwc && !auto_q |=> acq_sw_q == $past(pwdata[BWC_ACQ_BIT]))
    else $error("manual acquisition write lost");

  AST_LOCK_DROP: assert property (@(posedge pclk) disable iff (!presetn)
    loop_active && fb_rise && ref_per_q != '0 && diff > CNT_W'(UNL_TOL)
    |=> !lock_q)
    else $error("lock kept beyond unlock window");

endmodule // clock_gen_control
`default_nettype wire

/* src/vco_modulo_divider.sv */
`timescale 1ns/10ps
`default_nettype none
module vco_modulo_divider (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Divider control
  input wire logic enable,
  input wire logic [3:0] divisor,
  // VCO side
  input wire logic vco_level,
  input wire logic vco_rise,
  // Feedback side
  output logic fb_clk_q,
  output logic fb_rise
);

  logic [3:0] cnt_q;
  logic [3:0] n_eff;
  logic [3:0] half;

  // Zero multiplier behaves as one
  assign n_eff = (divisor == 4'h0) ? 4'h1 : divisor;
  // Widened sum: a divide by fifteen must not wrap to a zero high phase
  assign half = 4'(({1'b0, n_eff} + 5'h01) >> 1);
  assign fb_rise = enable && vco_rise && (cnt_q == 4'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
    end else if (!enable) begin
      cnt_q <= 4'h0;
    end else if (vco_rise) begin
      cnt_q <= (cnt_q >= n_eff - 4'h1) ? 4'h0 : cnt_q + 4'h1;
    end
  end

  // Divide by one passes the VCO level straight through
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_clk_q <= 1'b0;
    end else if (!enable) begin
      fb_clk_q <= 1'b0;
    end else if (n_eff == 4'h1) begin
      fb_clk_q <= vco_level;
    end else if (vco_rise) begin
      fb_clk_q <= (cnt_q < half);
    end
  end

  AST_FB_ON_VCO_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    fb_rise |-> vco_rise && enable ##1 fb_clk_q)
    else $error("feedback edge without a VCO edge");

endmodule // vco_modulo_divider
`default_nettype wire
